// ==== id_bit_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
`include "id_readout_map.svh"
module id_bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = `ID_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready && clk_en;
   assign pop = out_valid && out_ready && clk_en;
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : id_bit_fifo

// ==== id_readout_ctrl.sv ====
// Controller end: reads the identifier into a bit FIFO
`timescale 1ns/1ns
`include "id_readout_map.svh"
module id_readout_ctrl
   import id_readout_pkg::*;
#(
   parameter int ID_W = `ID_WIDTH,
   parameter int DEPTH = `ID_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // User request
   input wire logic start,
   input wire logic recirc,
   input wire logic fill_bit,
   output logic busy,
   // Bit stream out
   output logic bit_valid,
   input wire logic bit_ready,
   output logic bit_data,
   // Link
   id_readout_if.controller port
);
   // ****************************************
   // Sequencer
   // ****************************************
   reader_state_t st_q;
   logic [7:0] cnt_q;
   logic read_q;
   logic fifo_ready;
   logic take;
   // Stall shifting whenever the FIFO is full so no bit is lost
   assign take = (st_q == st_shift) && fifo_ready;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= st_idle;
         cnt_q <= '0;
      end else if (clk_en) begin
         case (st_q)
            st_idle: begin
               if (start) begin
                  st_q <= st_load;
               end
            end
            st_load: begin
               st_q <= st_shift;
               cnt_q <= '0;
            end
            st_shift: begin
               if (take) begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == 8'(ID_W - 1)) begin
                     st_q <= st_idle;
                  end
               end
            end
            default: st_q <= st_idle;
         endcase
      end
   end
   // Read is a single-cycle pulse, released before shifting
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         read_q <= 1'b0;
         busy <= 1'b0;
      end else if (clk_en) begin
         read_q <= (st_q == st_idle) && start; // RULE5
         busy <= (st_q != st_idle) || start;
      end
   end
   assign port.read = read_q;
   assign port.shift = take && (cnt_q != 8'(ID_W - 1));
   assign port.ser_in = recirc ? port.ser_out : fill_bit; // RULE9 RULE10
   assign port.test_instr = 2'h0;
   assign port.test_shift_dr = 1'b0;
   assign port.test_di = 1'b0;

   // ****************************************
   // Bit FIFO
   // ****************************************
   logic ov;
   logic od;
   id_bit_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .in_valid(take),
      .in_ready(fifo_ready),
      .in_data(port.ser_out),
      .out_valid(ov),
      .out_ready(bit_ready),
      .out_data(od)
   );
   // Registered output stage
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_valid <= 1'b0;
         bit_data <= 1'b0;
      end else if (clk_en) begin
         bit_valid <= ov && bit_ready;
         bit_data <= od;
      end
   end
endmodule : id_readout_ctrl

// ==== id_readout_if.sv ====
// Interface joining the readout port and its controlling logic
`timescale 1ns/1ns
interface id_readout_if;
   logic read;
   logic shift;
   logic ser_in;
   logic ser_out;
   logic [1:0] test_instr;
   logic test_shift_dr;
   logic test_di;
   logic test_do;
   modport device (input read, shift, ser_in, test_instr, test_shift_dr,
      test_di, output ser_out, test_do);
   modport controller (output read, shift, ser_in, test_instr,
      test_shift_dr, test_di, input ser_out, test_do);
endinterface : id_readout_if

// ==== id_readout_map.svh ====
// Constants for the unique-id serial readout
`ifndef ID_READOUT_MAP_SVH
`define ID_READOUT_MAP_SVH
`define ID_WIDTH 96
`define ID_CNT_W 7
`define ID_LSB_MARK 2'b01
`define ID_MSB_MARK 2'b01
`define ID_FIFO_DEPTH 32
`define ID_USER_FUSE_WIDTH 32
`define ID_INSTR_WIDTH 2
`endif

// ==== id_readout_pkg.sv ====
// Types for the unique-id serial readout
package id_readout_pkg;
   typedef enum logic [1:0] {
      instr_bypass_t_v = 2'h0,
      id_fuse_read_instr = 2'h1,
      user_fuse_read_instr = 2'h2
   } test_instr_t;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_load = 3'b010,
      st_shift = 3'b100
   } reader_state_t;
endpackage : id_readout_pkg

// ==== id_readout_port.sv ====
// Device end: unique-id shift register with user and test-port access
// Functional notes
// [RULE1] 96-bit id, fixed marker bits both ends
// [RULE2] Read high at edge loads all bits
// [RULE3] After load serial out shows bit0=1
// [RULE4] Read beats shift when both high
// [RULE5] Controller pulses read then releases it
// [RULE6] Shift moves toward output, input enters 95
// [RULE7] Serial out is always register bit 0
// [RULE8] Synchronous; neither control means hold
// [RULE9] Controller usually ties serial input constant
// [RULE10] Controller may recirculate output into input
// [RULE11] Controller may append bits via serial input
// [RULE12] Id test instruction drives bit0 at Shift-DR
// [RULE13] Shift-DR shifts remaining bits, then input
// [RULE14] User fuse readable by its own instruction
// [RULE15] Ninety-five shifts bring bit 95 out
`timescale 1ns/1ns
`include "id_readout_map.svh"
module id_readout_port
   import id_readout_pkg::*;
#(
   parameter int ID_W = `ID_WIDTH,
   parameter int UF_W = `ID_USER_FUSE_WIDTH,
   parameter logic [ID_W-5:0] ID_BODY = '0,
   parameter logic [UF_W-1:0] USER_FUSE = '0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Link
   id_readout_if.device port
);
   // ****************************************
   // Stored identifier
   // ****************************************
   // Marker bits let a reader find both ends of the word
   logic [ID_W-1:0] id_value;
   assign id_value = {`ID_MSB_MARK, ID_BODY, `ID_LSB_MARK}; // RULE1

   // ****************************************
   // User shift register
   // ****************************************
   logic [ID_W-1:0] sr_q;
   logic out_q;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sr_q <= '0;
      end else if (clk_en) begin
         if (port.read) begin
            sr_q <= id_value; // RULE2 RULE4
         end else if (port.shift) begin
            sr_q <= {port.ser_in, sr_q[ID_W-1:1]}; // RULE6 RULE15
         end
      end
   end
   // Output flop mirrors next bit 0 so it lines up with the register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= 1'b0;
      end else if (clk_en) begin
         if (port.read) begin
            out_q <= id_value[0]; // RULE3
         end else if (port.shift) begin
            out_q <= sr_q[1]; // RULE7
         end
      end
   end
   assign port.ser_out = out_q; // RULE8

   // ****************************************
   // Test-port data register
   // ****************************************
   // Loaded while outside Shift-DR, so bit 0 is ready on entry
   logic [ID_W-1:0] tr_q;
   logic tdo_q;
   logic [ID_W-1:0] tr_load;
   always_comb begin
      tr_load = '0;
      case (port.test_instr)
         id_fuse_read_instr: tr_load = id_value;
         user_fuse_read_instr: tr_load[UF_W-1:0] = USER_FUSE; // RULE14
         default: tr_load = '0;
      endcase
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tr_q <= '0;
      end else if (clk_en) begin
         if (!port.test_shift_dr) begin
            tr_q <= tr_load; // RULE12
         end else begin
            tr_q <= {port.test_di, tr_q[ID_W-1:1]}; // RULE13
         end
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tdo_q <= 1'b0;
      end else if (clk_en) begin
         tdo_q <= port.test_shift_dr ? tr_q[1] : tr_load[0]; // RULE12
      end
   end
   assign port.test_do = tdo_q;
endmodule : id_readout_port

// ==== id_readout_port_assertions.sv ====
// Checker for the unique-id readout link
`timescale 1ns/1ns
module id_readout_checker #(
   parameter logic [91:0] ID_BODY = '0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Link
   input wire logic read,
   input wire logic shift,
   input wire logic ser_in,
   input wire logic ser_out
);
   logic [95:0] sh_q;
   logic [6:0] cnt_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ********************
   // Shadow of the register
   // ********************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) sh_q <= '0;
      else if (read) sh_q <= {2'b01, ID_BODY, 2'b01};
      else if (shift) sh_q <= {ser_in, sh_q[95:1]};
   end
   // Saturates so a long recirculation never aliases a position
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) cnt_q <= 7'h7f;
      else if (read) cnt_q <= 7'h0;
      else if (shift && cnt_q != 7'h7f) cnt_q <= cnt_q + 7'h1;
   end
   a_load_mark: assert property (read |=> ser_out)
      else $error("load did not show bit 0");
   a_track_reg: assert property (ser_out == sh_q[0])
      else $error("serial out off register bit 0");
   a_hold_idle: assert property (!read && !shift |=> $stable(ser_out))
      else $error("output moved while idle");
   a_low_mark: assert property (cnt_q == 7'h1 |-> !ser_out)
      else $error("bit 1 marker wrong");
   a_top_mark: assert property (cnt_q == 7'h5e |-> ser_out)
      else $error("bit 94 marker wrong");
   a_last_bit: assert property (cnt_q == 7'h5f |-> !ser_out)
      else $error("bit 95 marker wrong");
   a_read_pulse: assert property ($rose(read) |=> !read)
      else $error("read held too long");
   a_read_done: assert property ($rose(read) |-> ##[1:1000] cnt_q == 7'h5f)
      else $error("readout did not reach bit 95");
   cover property ($rose(read));
   cover property (cnt_q == 7'h5f);
   cover property (shift && !read);
endmodule : id_readout_checker

// ==== unique_id_serial_readout_tb.sv ====
// Testbench for the unique-id serial readout
`timescale 1ns/1ns
module unique_id_serial_readout_tb;
   localparam logic [91:0] BODY = 92'h0f3_c5a5_96e1_8d2b_47ac_39e7;
   localparam logic [31:0] UF = 32'h5a5a_c33c;
   localparam logic [95:0] ID = {2'b01, BODY, 2'b01};
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic recirc = 1'b0;
   logic fill_bit = 1'b0;
   logic bit_ready = 1'b0;
   logic busy, bit_valid, bit_data;
   int err_count = 0;
   int cmp_count = 0;
   int n, i, j;
   id_readout_if u_id_readout_if();
   id_readout_if u_id_readout_if_b();
   id_readout_port #(.ID_BODY(BODY), .USER_FUSE(UF)) u_id_readout_port (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
      .port(u_id_readout_if.device));
   // Second device end driven straight from the bench
   id_readout_port #(.ID_BODY(BODY), .USER_FUSE(UF)) u_id_readout_port_b (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
      .port(u_id_readout_if_b.device));
   id_readout_ctrl u_id_readout_ctrl (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .start(start),
      .recirc(recirc), .fill_bit(fill_bit), .busy(busy),
      .bit_valid(bit_valid), .bit_ready(bit_ready), .bit_data(bit_data),
      .port(u_id_readout_if.controller));
   id_readout_checker #(.ID_BODY(BODY)) u_id_readout_checker (
      .ref_clk(ref_clk), .reset_n(reset_n), .read(u_id_readout_if.read),
      .shift(u_id_readout_if.shift), .ser_in(u_id_readout_if.ser_in),
      .ser_out(u_id_readout_if.ser_out));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // ********************
   // Tasks
   // ********************
   task automatic give_verdict();
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic v, input logic e);
      cmp_count++;
      if (v !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, v);
      end
   endtask : chk
   // Each step checks what the step before it left on the output
   task automatic step(input logic r, s, d, e);
      @(posedge ref_clk);
      u_id_readout_if_b.read <= r;
      u_id_readout_if_b.shift <= s;
      u_id_readout_if_b.ser_in <= d;
      @(negedge ref_clk);
      chk("ser_out", u_id_readout_if_b.ser_out, e);
   endtask : step
   task automatic tstep(input logic [1:0] c, input logic sd, d, v, e);
      @(posedge ref_clk);
      u_id_readout_if_b.test_instr <= c;
      u_id_readout_if_b.test_shift_dr <= sd;
      u_id_readout_if_b.test_di <= d;
      @(negedge ref_clk);
      if (v) chk("test_do", u_id_readout_if_b.test_do, e);
   endtask : tstep
   // Stall long enough to fill the FIFO; a second start is refused
   task automatic run(input logic rc, fb, tg);
      int k;
      n = 0;
      @(posedge ref_clk);
      recirc <= rc;
      fill_bit <= fb;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      for (k = 0; k < 3000 && (n < 96 || busy !== 1'b0); k++) begin
         // Valid is a one-cycle pulse per bit already taken
         @(negedge ref_clk);
         if (bit_valid === 1'b1) begin
            if (n < 96) chk("bit_data", bit_data, ID[n]);
            n++;
         end
         @(posedge ref_clk);
         start <= (k == 8);
         bit_ready <= tg ? k[0] : (k > 60);
      end
      if (k == 3000) begin
         err_count++;
         give_verdict();
      end
      chk("bit count", n == 96, 1'b1);
      $display("controller readout done");
   endtask : run
   initial begin
      u_id_readout_if_b.read = 1'b0;
      u_id_readout_if_b.shift = 1'b0;
      u_id_readout_if_b.ser_in = 1'b0;
      u_id_readout_if_b.test_instr = 2'h0;
      u_id_readout_if_b.test_shift_dr = 1'b0;
      u_id_readout_if_b.test_di = 1'b0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      run(1'b0, 1'b0, 1'b0);
      run(1'b1, 1'b1, 1'b1);
      step(1'b1, 1'b1, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b1);
      step(1'b0, 1'b0, 1'b0, 1'b1);
      for (j = 0; j < 98; j++) begin
         step(1'b0, 1'b1, j[0], j < 96 ? ID[j] : j[0]);
      end
      step(1'b0, 1'b0, 1'b0, 1'b0);
      $display("user port shifting done");
      for (i = 0; i < 3; i++) begin
         tstep(i[1:0], 1'b0, 1'b0, 1'b0, 1'b0);
         for (j = 0; j < 100; j++) begin
            tstep(2'h0, 1'b1, j[1], i == 1 || j < 32, i == 1 ?
               (j < 96 ? ID[j] : j[1]) : (i == 2) & UF[j[4:0]]);
         end
         tstep(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      end
      $display("test port readout done");
      give_verdict();
   end
endmodule : unique_id_serial_readout_tb
